// >>> core/cmt_map.svh
// Offsets, field positions, reset values and timing counts of the coax transceiver
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CMT_OFS_CTRL 8'h00
`define CMT_OFS_TX 8'h04
`define CMT_OFS_RX 8'h08
`define CMT_OFS_STAT 8'h0C
`define CMT_OFS_CLR 8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CMT_CTRL_RESET 4'hB
`define CMT_CLR_AVAIL 0

// ----------------------------------------
// Timing counts in clock cycles, half-bit periods and bits
// ----------------------------------------
`define CMT_BIT_CLKS 8
`define CMT_HALF_LAST 2'h3
`define CMT_QUIET_LAST 5'h09
`define CMT_CV_LAST 5'h05
`define CMT_CV_HIGH 5'h03
`define CMT_WORD_LAST 5'h15
`define CMT_RX_LAST_BIT 4'hC
`define CMT_LIMIT_CLKS 2'h3
`define CMT_QUIET_MIN 3'h4
`define CMT_SHORT_MIN 4'h2
`define CMT_SHORT_MAX 4'h5
`define CMT_LONG_MAX 4'h9
`define CMT_VIOL_MAX 4'hE

`endif

// >>> core/cmt_pkg.sv
// Types shared by the coax transceiver
package cmt_pkg;

    // ----------------------------------------
    // State machines
    // ----------------------------------------
    typedef enum logic [8:0] {
        TX_IDLE = 9'h001,
        TX_LEAD = 9'h002,
        TX_QUIET = 9'h004,
        TX_CV = 9'h008,
        TX_SYNC = 9'h010,
        TX_DATA = 9'h020,
        TX_END = 9'h040,
        TX_MINI = 9'h080,
        TX_SPARE = 9'h100
    } cmt_tx_state_type;

    typedef enum logic [2:0] {
        RX_HUNT = 3'h1,
        RX_CV = 3'h2,
        RX_WORD = 3'h4
    } cmt_rx_state_type;

    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic rx_parity_sel;
        logic rx_pulse_limiter_en;
        logic internal_wrap_n;
        logic line_loopback_n;
    } cmt_ctrl_type;

    typedef struct packed {
        logic tx_word_parity_sel;
        logic ninth_bit_select;
        logic tx_tenth_bit;
        logic tx_ninth_bit;
        logic [7:0] data;
    } cmt_tx_word_type;

endpackage

// >>> core/cmt_transceiver.sv
// Coax Manchester transceiver with a Wishbone register port
`timescale 1ns/1ps
`include "cmt_map.svh"
module cmt_transceiver (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Line side
    input wire logic rx_serial_i,
    output logic serial_tx_out_o,
    output logic predistort_clock_out_o,
    output logic tx_gate_n_o
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic par_bit(input logic [10:0] v, input logic even);
        par_bit = even ? ^v : ~^v;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    cmt_pkg::cmt_ctrl_type ctrl;
    cmt_pkg::cmt_tx_word_type hold;
    cmt_pkg::cmt_tx_state_type tx_st;
    cmt_pkg::cmt_tx_state_type next_tx_st;
    cmt_pkg::cmt_rx_state_type rx_st;
    cmt_pkg::cmt_rx_state_type next_rx_st;
    logic hold_full;
    logic [1:0] div;
    logic [4:0] hc;
    logic [4:0] next_hc;
    logic load_sh;
    logic [10:0] sh;
    logic word_available;
    logic start_seq_seen;
    logic turnaround_flag;
    logic [9:0] rx_hold;
    logic [1:0] pl_cnt;
    logic rx_lvl;
    logic rx_prev;
    logic [3:0] run;
    logic mid;
    logic next_mid;
    logic [2:0] qcnt;
    logic [2:0] next_qcnt;
    logic [3:0] bcnt;
    logic [12:0] rsh;
    logic got_bit;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic [7:0] adr_word = {wb_adr_i[7:2], 2'b00};
    wire logic wr = wb_req & wb_we_i & wb_sel_i[0];
    wire logic hit_ctrl = adr_word == `CMT_OFS_CTRL;
    wire logic hit_tx = adr_word == `CMT_OFS_TX;
    wire logic hit_rx = adr_word == `CMT_OFS_RX;
    wire logic hit_stat = adr_word == `CMT_OFS_STAT;
    wire logic hit_clr = adr_word == `CMT_OFS_CLR;
    wire logic tx_load_strobe_n = ~(wr & hit_tx & ~hold_full);
    wire logic ld_tx = ~tx_load_strobe_n;
    wire logic clear_word_avail_n = ~(wr & hit_clr & wb_dat_i[`CMT_CLR_AVAIL]);
    wire logic clr_avail = ~clear_word_avail_n;
    wire logic tx_active = tx_st != cmt_pkg::TX_IDLE;
    wire logic tx_holding_empty = ~hold_full;
    wire logic [4:0] status = {tx_active, tx_holding_empty, turnaround_flag,
                               start_seq_seen, word_available};

    wire logic [31:0] rd_mux = hit_ctrl ? {28'h000_0000, ctrl} :
                               hit_tx ? {20'h0_0000, hold} :
                               hit_rx ? {22'h00_0000, rx_hold} :
                               hit_stat ? {27'h000_0000, status} :
                               32'h0000_0000;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= cmt_pkg::cmt_ctrl_type'(`CMT_CTRL_RESET);
        end else if (wr & hit_ctrl) begin
            ctrl <= cmt_pkg::cmt_ctrl_type'(wb_dat_i[3:0]);
        end
    end

    // ----------------------------------------
    // Transmit holding register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold <= cmt_pkg::cmt_tx_word_type'(12'h000);
        end else if (ld_tx) begin
            hold <= cmt_pkg::cmt_tx_word_type'(wb_dat_i[11:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_full <= 1'b0;
        end else if (ld_tx) begin
            hold_full <= 1'b1;
        end else if (load_sh) begin
            hold_full <= 1'b0;
        end
    end

    // ----------------------------------------
    // Parity generation
    // ----------------------------------------
    wire logic ninth_out = hold.ninth_bit_select ?
        par_bit({3'h0, hold.data}, hold.tx_ninth_bit) : hold.tx_ninth_bit;
    wire logic [9:0] word10 = {hold.tx_tenth_bit, ninth_out, hold.data};
    wire logic word_par = par_bit({1'b0, word10}, hold.tx_word_parity_sel);

    // ----------------------------------------
    // Bit timing divider
    // ----------------------------------------
    wire logic start_tx = ld_tx & ~tx_active;
    wire logic half_tick = div == `CMT_HALF_LAST;

    always_ff @(posedge clk_i) begin
        if (rst_i | start_tx) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end

    // ----------------------------------------
    // Transmit sequencer
    // ----------------------------------------
    always_comb begin
        next_tx_st = tx_st;
        next_hc = hc;
        load_sh = 1'b0;
        if (half_tick) begin
            next_hc = hc + 5'h01;
            case (tx_st)
                cmt_pkg::TX_LEAD: begin
                    next_tx_st = cmt_pkg::TX_QUIET;
                    next_hc = 5'h00;
                end
                cmt_pkg::TX_QUIET: begin
                    if (hc == `CMT_QUIET_LAST) begin
                        next_tx_st = cmt_pkg::TX_CV;
                        next_hc = 5'h00;
                    end
                end
                cmt_pkg::TX_CV: begin
                    if (hc == `CMT_CV_LAST) begin
                        next_tx_st = cmt_pkg::TX_SYNC;
                        next_hc = 5'h00;
                        load_sh = 1'b1;
                    end
                end
                cmt_pkg::TX_SYNC: begin
                    if (hc == 5'h01) begin
                        next_tx_st = cmt_pkg::TX_DATA;
                        next_hc = 5'h00;
                    end
                end
                cmt_pkg::TX_DATA: begin
                    if (hc == `CMT_WORD_LAST) begin
                        next_hc = 5'h00;
                        if (hold_full) begin
                            next_tx_st = cmt_pkg::TX_SYNC;
                            load_sh = 1'b1;
                        end else begin
                            next_tx_st = cmt_pkg::TX_END;
                        end
                    end
                end
                cmt_pkg::TX_END: begin
                    if (hc == 5'h01) begin
                        next_tx_st = cmt_pkg::TX_MINI;
                        next_hc = 5'h00;
                    end
                end
                cmt_pkg::TX_MINI: begin
                    if (hc == 5'h01) begin
                        next_tx_st = cmt_pkg::TX_IDLE;
                        next_hc = 5'h00;
                    end
                end
                default: begin
                    next_tx_st = cmt_pkg::TX_IDLE;
                    next_hc = 5'h00;
                end
            endcase
        end
        if (start_tx) begin
            next_tx_st = cmt_pkg::TX_LEAD;
            next_hc = 5'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st <= cmt_pkg::TX_IDLE;
            hc <= 5'h00;
        end else begin
            tx_st <= next_tx_st;
            hc <= next_hc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh <= 11'h000;
        end else if (load_sh) begin
            sh <= {word_par, word10};
        end else if (half_tick & hc[0] & (tx_st == cmt_pkg::TX_DATA)) begin
            sh <= {1'b0, sh[10:1]};
        end
    end

    // ----------------------------------------
    // Line level and gate
    // ----------------------------------------
    wire logic cur_bit = (tx_st == cmt_pkg::TX_SYNC) ? 1'b1 :
                         (tx_st == cmt_pkg::TX_END) ? 1'b0 : sh[0];
    wire logic bit_lvl = hc[0] ? cur_bit : ~cur_bit;
    wire logic in_bits = (tx_st == cmt_pkg::TX_SYNC) | (tx_st == cmt_pkg::TX_DATA) |
                         (tx_st == cmt_pkg::TX_END);
    wire logic next_td = in_bits ? bit_lvl :
                         (tx_st == cmt_pkg::TX_QUIET) ? hc[0] :
                         (tx_st == cmt_pkg::TX_CV) ? (hc >= `CMT_CV_HIGH) :
                         (tx_st == cmt_pkg::TX_MINI) ? 1'b0 : 1'b1;
    wire logic gate_on = tx_active & (tx_st != cmt_pkg::TX_MINI);
    wire logic next_gate_n = ~ctrl.internal_wrap_n | ~gate_on;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_tx_out_o <= 1'b1;
            tx_gate_n_o <= 1'b1;
            predistort_clock_out_o <= 1'b0;
        end else begin
            serial_tx_out_o <= next_td;
            tx_gate_n_o <= next_gate_n;
            predistort_clock_out_o <= div[0];
        end
    end

    // ----------------------------------------
    // Receive source selection
    // ----------------------------------------
    wire logic both_hi = ctrl.line_loopback_n & ctrl.internal_wrap_n;
    wire logic both_lo = ~ctrl.line_loopback_n & ~ctrl.internal_wrap_n;
    wire logic rx_en = both_lo ? 1'b0 :
                       both_hi ? ~tx_active :
                       tx_active;
    wire logic rx_src = ctrl.internal_wrap_n ? rx_serial_i : serial_tx_out_o;
    wire logic rx_in = rx_en & rx_src;
    wire logic lim_in = ctrl.rx_pulse_limiter_en ?
        (rx_in & (pl_cnt != `CMT_LIMIT_CLKS)) : rx_in;

    always_ff @(posedge clk_i) begin
        if (rst_i | ~rx_in) begin
            pl_cnt <= 2'h0;
        end else if (pl_cnt != `CMT_LIMIT_CLKS) begin
            pl_cnt <= pl_cnt + 2'h1;
        end
    end

    // ----------------------------------------
    // Transition timing
    // ----------------------------------------
    wire logic edge_seen = rx_lvl != rx_prev;
    wire logic is_short = (run >= `CMT_SHORT_MIN) & (run <= `CMT_SHORT_MAX);
    wire logic is_long = (run > `CMT_SHORT_MAX) & (run <= `CMT_LONG_MAX);
    wire logic is_viol = (run > `CMT_LONG_MAX) & (run <= `CMT_VIOL_MAX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_lvl <= 1'b0;
            rx_prev <= 1'b0;
            run <= 4'h0;
        end else begin
            rx_lvl <= lim_in;
            rx_prev <= rx_lvl;
            run <= edge_seen ? 4'h1 : (run == 4'hF) ? run : run + 4'h1;
        end
    end

    // ----------------------------------------
    // Receive decoder
    // ----------------------------------------
    always_comb begin
        next_rx_st = rx_st;
        next_mid = mid;
        next_qcnt = (rx_st == cmt_pkg::RX_HUNT) ? qcnt : 3'h0;
        got_bit = 1'b0;
        if (edge_seen) begin
            case (rx_st)
                cmt_pkg::RX_HUNT: begin
                    if (is_short) begin
                        next_qcnt = (qcnt == 3'h7) ? qcnt : qcnt + 3'h1;
                    end else if (is_viol & ~rx_prev & (qcnt >= `CMT_QUIET_MIN) &
                                 ~ctrl.rx_pulse_limiter_en) begin
                        next_rx_st = cmt_pkg::RX_CV;
                    end else begin
                        next_qcnt = 3'h0;
                    end
                end
                cmt_pkg::RX_CV: begin
                    if (is_viol & rx_prev) begin
                        next_rx_st = cmt_pkg::RX_WORD;
                        next_mid = 1'b0;
                    end else begin
                        next_rx_st = cmt_pkg::RX_HUNT;
                    end
                end
                cmt_pkg::RX_WORD: begin
                    if (mid & is_short) begin
                        next_mid = 1'b0;
                    end else if (mid & is_long) begin
                        got_bit = 1'b1;
                    end else if (~mid & is_short) begin
                        next_mid = 1'b1;
                        got_bit = 1'b1;
                    end else begin
                        next_rx_st = cmt_pkg::RX_HUNT;
                    end
                end
                default: begin
                    next_rx_st = cmt_pkg::RX_HUNT;
                end
            endcase
        end
        if (~rx_en) begin
            next_rx_st = cmt_pkg::RX_HUNT;
            next_qcnt = 3'h0;
        end
    end

    wire logic [12:0] nsh = {rx_lvl, rsh[12:1]};
    wire logic word_done = got_bit & (bcnt == `CMT_RX_LAST_BIT);
    wire logic par_ok = (^nsh[11:1]) ^ ctrl.rx_parity_sel;
    wire logic word_good = word_done & par_ok;
    wire logic ss_set = got_bit & (bcnt == 4'h0) & rx_lvl;
    wire logic ta_set = word_good & ~rx_lvl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st <= cmt_pkg::RX_HUNT;
            mid <= 1'b0;
            qcnt <= 3'h0;
        end else begin
            rx_st <= next_rx_st;
            mid <= next_mid;
            qcnt <= next_qcnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i | (next_rx_st != cmt_pkg::RX_WORD)) begin
            bcnt <= 4'h0;
        end else if (word_done) begin
            bcnt <= {3'h0, rx_lvl};
        end else if (got_bit) begin
            bcnt <= bcnt + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsh <= 13'h0000;
        end else if (got_bit) begin
            rsh <= nsh;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_hold <= 10'h000;
        end else if (word_done) begin
            rx_hold <= nsh[10:1];
        end
    end

    // ----------------------------------------
    // Receive status flags
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_available <= 1'b0;
            start_seq_seen <= 1'b0;
            turnaround_flag <= 1'b0;
        end else begin
            word_available <= word_good | (word_available & ~clr_avail);
            start_seq_seen <= ss_set | (start_seq_seen & ~ld_tx);
            turnaround_flag <= ta_set | (turnaround_flag & ~(ld_tx | clr_avail));
        end
    end

endmodule

// >>> verification/cmt_transceiver_chk.sv
// Port assertions for the coax transceiver
`timescale 1ns/1ps
module cmt_transceiver_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Line side
    input wire logic serial_tx_out_o,
    input wire logic predistort_clock_out_o,
    input wire logic tx_gate_n_o
);
    // ----------------------------------------
    // Run length of the line while the gate is on
    // ----------------------------------------
    logic [3:0] run;
    always_ff @(posedge clk_i) begin
        if (rst_i || tx_gate_n_o || $changed(serial_tx_out_o)) begin
            run <= 4'h0;
        end else if (run != 4'hF) begin
            run <= run + 4'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_lead; serial_tx_out_o [*3]; endsequence
    sequence s_back_idle; ##[1:16] serial_tx_out_o [*8]; endsequence
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_unmapped;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[7:2] > 6'h04
            |=> wb_dat_o == 32'h0000_0000;
    endproperty
    property p_reset_out; $fell(rst_i) |-> tx_gate_n_o && serial_tx_out_o && !wb_ack_o; endproperty
    property p_pclk;
        !$past(rst_i) && $stable(predistort_clock_out_o) |=> $changed(predistort_clock_out_o);
    endproperty
    property p_lead; $fell(tx_gate_n_o) |-> s_lead; endproperty
    property p_end; $rose(tx_gate_n_o) |-> s_back_idle; endproperty
    property p_mini_low; $rose(tx_gate_n_o) |-> ##[0:8] !serial_tx_out_o; endproperty
    property p_run; !tx_gate_n_o |-> run < 4'hD; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_reset_out: assert property (p_reset_out) else $error("outputs not at reset level");
    a_pclk: assert property (p_pclk) else $error("predistortion clock stalled");
    a_lead: assert property (p_lead) else $error("line not high at gate on");
    a_end: assert property (p_end) else $error("line not idle high after message");
    a_mini_low: assert property (p_mini_low) else $error("no low level at message end");
    a_run: assert property (p_run) else $error("line run too long for biphase");
endmodule

bind cmt_transceiver cmt_transceiver_chk u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .serial_tx_out_o, .predistort_clock_out_o, .tx_gate_n_o
);

// >>> verification/cmt_line_partner.sv
// Line model: coax driver and receiver between transmit output and receive input
`timescale 1ns/1ps
module cmt_line_partner (
    // Clock
    input wire logic clk_i,
    // Transmit side
    input wire logic tx_gate_n_i,
    input wire logic serial_tx_i,
    // Receive side
    output logic rx_serial_o = 1'b0
);
    // Echo through the cable while driven, else a floating line flipping every cycle
    always_ff @(posedge clk_i) begin
        if (!tx_gate_n_i) begin
            rx_serial_o <= serial_tx_i;
        end else begin
            rx_serial_o <= ~rx_serial_o;
        end
    end
endmodule

// >>> verification/cmt_transceiver_tb_top.sv
// Self-checking bench for the coax transceiver
`timescale 1ns/1ps
module cmt_transceiver_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [3:0] sel = 4'hF;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rx_serial, serial_tx_out_o, predistort_clock_out_o, tx_gate_n_o, gate_q;
    int miscompares = 0;
    int n_tests = 0;
    int falls = 0;
    // ----------------------------------------
    // Clock, design and line
    // ----------------------------------------
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    cmt_transceiver uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
        .rx_serial_i(rx_serial), .serial_tx_out_o, .predistort_clock_out_o, .tx_gate_n_o);
    cmt_line_partner line (.clk_i, .tx_gate_n_i(tx_gate_n_o), .serial_tx_i(serial_tx_out_o),
        .rx_serial_o(rx_serial));
    always @(posedge clk_i) begin
        gate_q <= tx_gate_n_o;
        if (gate_q === 1'b1 && tx_gate_n_o === 1'b0) falls++;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 20, 1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    function automatic logic [31:0] rx_of(input logic [11:0] w);
        logic p;
        p = w[10] ? (w[8] ? ^w[7:0] : ~^w[7:0]) : w[8];
        return {22'h0, w[9], p, w[7:0]};
    endfunction
    // Mode 1: second load at once, mode 2: second load once holding is empty
    task automatic send(input logic [3:0] c, input logic [11:0] w, input int m, input logic [11:0] w2);
        int n;
        n = 0;
        bus(1'b1, 8'h10, 32'h0000_0001);
        bus(1'b1, 8'h00, {28'h0, c});
        bus(1'b1, 8'h04, {20'h0, w});
        bus(1'b0, 8'h0C, 32'h0000_0000);
        chk(q & 32'h0000_0008, 32'h0000_0000);
        if (m == 1) bus(1'b1, 8'h04, {20'h0, w2});
        while (m == 2 && q[3] !== 1'b1 && n < 100) begin
            bus(1'b0, 8'h0C, 32'h0000_0000);
            n++;
        end
        if (m == 2) bus(1'b1, 8'h04, {20'h0, w2});
        bus(1'b0, 8'h0C, 32'h0000_0000);
        while (q[4] !== 1'b0 && n < 200) begin
            bus(1'b0, 8'h0C, 32'h0000_0000);
            n++;
        end
        chk(n < 200, 1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(8'h00, 32'h0000_000B);
        rd(8'h0C, 32'h0000_0008);
        chk({30'h0, serial_tx_out_o, tx_gate_n_o}, 32'h0000_0003);
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0000_0000);
        sel <= 4'hE;
        bus(1'b1, 8'h00, 32'h0000_0000);
        sel <= 4'hF;
        rd(8'h00, 32'h0000_000B);
    endtask
    task automatic t_loop;
        int f0;
        f0 = falls;
        send(4'hA, 12'h9A5, 1, 12'h8FF);
        rd(8'h08, rx_of(12'h9A5));
        rd(8'h0C, 32'h0000_000F);
        chk(falls - f0, 1);
        bus(1'b1, 8'h10, 32'h0000_0001);
        rd(8'h0C, 32'h0000_000A);
    endtask
    task automatic t_multi;
        int f0;
        f0 = falls;
        send(4'hA, 12'h9A5, 2, 12'h833);
        rd(8'h08, rx_of(12'h833));
        rd(8'h0C, 32'h0000_000F);
        chk(falls - f0, 1);
    endtask
    task automatic t_ninth;
        logic [11:0] w;
        for (int i = 0; i < 2; i++) begin
            w = {3'h7, i[0], 8'h03};
            send(4'hA, w, 0, 12'h000);
            rd(8'h08, rx_of(w));
        end
    endtask
    task automatic t_parity;
        for (int i = 0; i < 2; i++) begin
            send(4'h2, {i[0], 3'h0, 8'h5A}, 0, 12'h000);
            rd(8'h0C, i ? 32'h0000_000A : 32'h0000_000F);
        end
    endtask
    task automatic t_mode(input logic [3:0] c, input logic [31:0] st, input int df);
        int f0;
        f0 = falls;
        send(c, 12'h9A5, 0, 12'h000);
        rd(8'h0C, st);
        chk(falls - f0, df);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_loop;
        t_multi;
        t_ninth;
        t_parity;
        t_mode(4'hB, 32'h0000_0008, 1);
        t_mode(4'h9, 32'h0000_000F, 0);
        t_mode(4'hE, 32'h0000_0008, 1);
        t_mode(4'h8, 32'h0000_0008, 0);
        print_verdict;
    end
endmodule
